// ===== pkg/cal_ctrl_regs.svh
`ifndef CAL_CTRL_REGS_SVH
`define CAL_CTRL_REGS_SVH
// Register offsets on the reconfiguration address space.
`define OFS_ARB 11'h000
`define OFS_CAL_EN 11'h100
`define OFS_PLL_STAT 11'h480
`define OFS_CH_STAT 11'h481
// Field positions in the arbitration register.
`define ARB_OWNER_BIT 0
`define ARB_DONE_BIT 1
// Field positions in the calibration enable register.
`define EN_RX_BIT 0
`define EN_TX_BIT 1
`define EN_LC_PLL_BIT 0
`define EN_FRAC_PLL_BIT 1
`define EN_RATE_BIT 3
// Field positions in the status registers.
`define ST_TX_BUSY_BIT 0
`define ST_RX_BUSY_BIT 1
`define ST_OWNER_BIT 2
`define ST_TX_GATE_BIT 4
`define ST_RX_GATE_BIT 5
`define ST_PLL_BUSY_BIT 1
// Reset values.
`define CAL_EN_RESET 8'h00
`define GATE_RESET 1'b1
// Cycles from a cleared done bit to the busy indication.
`define BUSY_DELAY 2
// Calibration run length of the engine model, in cycles.
`define CAL_RUN_CYCLES 8'h10
`endif

// ===== pkg/cal_ctrl_pkg.sv
package cal_ctrl_pkg;
  // One register access request from the reconfiguration host.
  typedef struct packed {
    logic read;
    logic write;
    logic [10:0] address;
    logic [7:0] writedata;
  } reg_req_type;
  // Ownership of the shared configuration bus.
  typedef enum logic {owner_user_type_v, owner_engine_type_v} owner_type;
  // Engine sequencing states.
  typedef enum {eng_idle, eng_wait, eng_run} eng_state_type;
endpackage

// ===== design/busy_delay_line.sv
`timescale 1ns/1ps
// Fixed delay line for a single event pulse.
module busy_delay_line #(
  parameter int DEPTH = 2
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic pulse_in,
  output logic pulse_out
);
  // Shift register; one stage per cycle of delay.
  logic [DEPTH-1:0] stage_r;

  // The event marches through the stages and emerges DEPTH cycles later.
  always_ff @(posedge clk) begin
    if (reset) begin
      stage_r <= '0;
    end else begin
      stage_r <= {stage_r[DEPTH-2:0], pulse_in};
    end
  end

  assign pulse_out = stage_r[DEPTH-1];
endmodule

// ===== design/transceiver_calibration_control_regs.sv
`timescale 1ns/1ps
`include "cal_ctrl_regs.svh"
// Function
// - Bit zero of 0x0 selects bus owner.
// - Bit one of 0x0 reads inverse busy.
// - Busy rises two cycles after done cleared.
// - calibration_enable_and_rate_flag holds receive and transmit enables.
// - Receive calibration also covers CDR, local PLL.
// - PLL mode: bit0 LC/local, bit1 fractional.
// - Status registers readable without any arbitration.
// - channel_calibration_status bit5 gates receive busy, default one.
// - channel_calibration_status bit4 gates transmit busy, default one.
// - Gating unsupported with merged simplex channels.
// - channel_calibration_status bit2 shows engine bus ownership.
// - channel_calibration_status bits1:0 show receive, transmit busy.
// - pll_calibration_status shows ownership and PLL busy.
// - calibration_enable_and_rate_flag bit3 rate flag, default zero.
// - Waitrequest high on accesses other than status or 0x0 while engine owns, unless separated.
module transceiver_calibration_control_regs
  import cal_ctrl_pkg::*;
#(
  parameter bit PLL_MODE = 1'b0,
  parameter bit SEPARATE_WAITREQ = 1'b0,
  parameter bit MERGED_SIMPLEX = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic read,
  input wire logic write,
  input wire logic [10:0] address,
  input wire logic [7:0] writedata,
  output logic [7:0] readdata,
  output logic waitrequest,
  output logic tx_cal_busy,
  output logic rx_cal_busy,
  output logic pll_cal_busy,
  output logic [7:0] cal_enable_out,
  output logic rate_switch_out
);
  // Bundled request, so decode below reads one carrier.
  reg_req_type req;
  // Current owner of the internal configuration bus.
  owner_type owner_r;
  // Calibration done bit; reset shows complete.
  logic done_r;
  // Calibration enable and rate flag register.
  logic [7:0] cal_en_r;
  // Busy output gates held in the channel status register.
  logic tx_gate_r;
  logic rx_gate_r;
  // Engine state and its run counter.
  eng_state_type eng_r;
  logic [7:0] run_cnt_r;
  // Raw busy from the engine, shared by both directions.
  logic cal_busy_r;
  // Pulse when the host clears the done bit.
  logic done_clear;
  // Same pulse after the fixed delay.
  logic busy_start;
  // Decoded accesses.
  logic hit_arb, hit_en, hit_pll, hit_ch;
  logic user_owns;
  logic accept_wr;
  // Per-direction gated busy terms.
  logic tx_busy_g, rx_busy_g;
  // Status words.
  logic [7:0] ch_stat, pll_stat;

  assign req = '{read: read, write: write, address: address, writedata: writedata};
  assign hit_arb = (req.address == `OFS_ARB);
  assign hit_en = (req.address == `OFS_CAL_EN);
  assign hit_pll = (req.address == `OFS_PLL_STAT);
  assign hit_ch = (req.address == `OFS_CH_STAT);
  assign user_owns = (owner_r == owner_user_type_v);

  // Status words live in fabric and are always reachable, so only other
  // addresses are stalled while the engine holds the bus.
  always_comb begin
    waitrequest = 1'b0;
    if (!SEPARATE_WAITREQ && !user_owns) begin
      // Arbitration register must stay writable so the host can reclaim.
      waitrequest = (req.read || req.write) && !hit_pll && !hit_ch && !hit_arb;
    end
  end

  // A write is accepted when the owner check passes for its target.
  assign accept_wr = req.write && !waitrequest && (user_owns || hit_arb || hit_ch);

  // Detect a host write of zero to the done bit.
  assign done_clear = accept_wr && hit_arb && !req.writedata[`ARB_DONE_BIT];

  // Busy follows the clear by exactly two cycles.
  busy_delay_line #(
    .DEPTH(`BUSY_DELAY)
  ) u_delay (
    .clk(clk),
    .reset(reset),
    .pulse_in(done_clear),
    .pulse_out(busy_start)
  );

  // Bus ownership bit: zero requests user, one returns to the engine.
  always_ff @(posedge clk) begin
    if (reset) begin
      owner_r <= owner_user_type_v;
    end else if (accept_wr && hit_arb) begin
      owner_r <= req.writedata[`ARB_OWNER_BIT] ? owner_engine_type_v : owner_user_type_v;
    end else if (eng_r == eng_idle && !cal_busy_r && owner_r == owner_engine_type_v &&
                 cal_en_r[`EN_TX_BIT:`EN_RX_BIT] == 2'b00) begin
      // With nothing left to run the engine keeps the bus until reclaimed.
      owner_r <= owner_r;
    end
  end

  // Done bit is the inverse of busy; host clears, engine end of run sets.
  always_ff @(posedge clk) begin
    if (reset) begin
      done_r <= 1'b1;
    end else if (eng_r == eng_run && run_cnt_r == 8'h01) begin
      done_r <= 1'b1;
    end else if (done_clear) begin
      done_r <= 1'b0;
    end else if (busy_start) begin
      done_r <= 1'b0;
    end
  end

  // Enable register; only the user may change it.
  always_ff @(posedge clk) begin
    if (reset) begin
      cal_en_r <= `CAL_EN_RESET;
    end else if (accept_wr && hit_en && user_owns) begin
      cal_en_r <= req.writedata;
    end
  end

  // Busy gates reset to one; merged simplex channels cannot use them.
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_gate_r <= `GATE_RESET;
      rx_gate_r <= `GATE_RESET;
    end else if (accept_wr && hit_ch && !MERGED_SIMPLEX) begin
      rx_gate_r <= req.writedata[`ST_RX_GATE_BIT];
      tx_gate_r <= req.writedata[`ST_TX_GATE_BIT];
    end
  end

  // Engine: a run starts when busy arrives and the engine owns the bus.
  always_ff @(posedge clk) begin
    if (reset) begin
      eng_r <= eng_idle;
      run_cnt_r <= 8'h00;
    end else begin
      case (eng_r)
        eng_idle: begin
          if (busy_start) begin
            eng_r <= eng_wait;
          end
        end
        eng_wait: begin
          // Calibration waits until the bus is handed to the engine.
          if (!user_owns) begin
            eng_r <= eng_run;
            run_cnt_r <= `CAL_RUN_CYCLES;
          end
        end
        eng_run: begin
          if (run_cnt_r == 8'h01) begin
            eng_r <= eng_idle;
          end
          run_cnt_r <= run_cnt_r - 8'h01;
        end
        default: begin
          eng_r <= eng_idle;
        end
      endcase
    end
  end

  // Raw busy: high from two cycles after the clear until the run ends.
  always_ff @(posedge clk) begin
    if (reset) begin
      cal_busy_r <= 1'b0;
    end else if (busy_start) begin
      cal_busy_r <= 1'b1;
    end else if (eng_r == eng_run && run_cnt_r == 8'h01) begin
      cal_busy_r <= 1'b0;
    end
  end

  // One internal node drives both directions; receive runs cover the
  // CDR and local PLL too, so rx enable alone already includes them.
  assign rx_busy_g = (cal_busy_r | busy_start) & (rx_gate_r | MERGED_SIMPLEX);
  assign tx_busy_g = (cal_busy_r | busy_start) & (tx_gate_r | MERGED_SIMPLEX);

  // Outputs follow the selected mode.
  always_ff @(posedge clk) begin
    if (reset) begin
      tx_cal_busy <= 1'b0;
      rx_cal_busy <= 1'b0;
      pll_cal_busy <= 1'b0;
    end else begin
      tx_cal_busy <= !PLL_MODE && tx_busy_g;
      rx_cal_busy <= !PLL_MODE && rx_busy_g;
      pll_cal_busy <= PLL_MODE && (cal_busy_r | busy_start);
    end
  end

  // Enables and rate flag go to the engine unchanged.
  always_ff @(posedge clk) begin
    if (reset) begin
      cal_enable_out <= `CAL_EN_RESET;
      rate_switch_out <= 1'b0;
    end else begin
      cal_enable_out <= cal_en_r;
      rate_switch_out <= cal_en_r[`EN_RATE_BIT];
    end
  end

  // Status words; reserved bits read as zero.
  always_comb begin
    ch_stat = 8'h00;
    ch_stat[`ST_RX_GATE_BIT] = rx_gate_r;
    ch_stat[`ST_TX_GATE_BIT] = tx_gate_r;
    ch_stat[`ST_OWNER_BIT] = !user_owns;
    ch_stat[`ST_RX_BUSY_BIT] = rx_cal_busy;
    ch_stat[`ST_TX_BUSY_BIT] = tx_cal_busy;
    pll_stat = 8'h00;
    pll_stat[`ST_OWNER_BIT] = !user_owns;
    pll_stat[`ST_PLL_BUSY_BIT] = pll_cal_busy;
  end

  // Read data registered one cycle after an accepted read.
  always_ff @(posedge clk) begin
    if (reset) begin
      readdata <= 8'h00;
    end else if (req.read && !waitrequest) begin
      if (hit_ch) begin
        readdata <= ch_stat;
      end else if (hit_pll) begin
        readdata <= pll_stat;
      end else if (hit_arb) begin
        readdata <= {6'h00, done_r, !user_owns};
      end else if (hit_en && user_owns) begin
        readdata <= cal_en_r;
      end else begin
        readdata <= 8'h00;
      end
    end
  end
endmodule

// ===== tb/transceiver_calibration_control_regs_checker.sv
`timescale 1ns/1ps
// Watches the register block from its ports only.
module transceiver_calibration_control_regs_checker #(
  parameter bit PLL_MODE = 1'b0,
  parameter bit SEPARATE_WAITREQ = 1'b0,
  parameter bit MERGED_SIMPLEX = 1'b0
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic read,
  input wire logic write,
  input wire logic [10:0] address,
  input wire logic [7:0] writedata,
  input wire logic [7:0] readdata,
  input wire logic waitrequest,
  input wire logic tx_cal_busy,
  input wire logic rx_cal_busy,
  input wire logic pll_cal_busy,
  input wire logic [7:0] cal_enable_out,
  input wire logic rate_switch_out
);
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  logic owner_r; // Expected bus owner, set by accepted writes to bit 0 of 0x0.
  logic [1:0] gate_r; // Expected busy gates, receive above transmit.
  logic [4:0] rxz_r; // Cycles the receive gate has been off, saturating.
  logic [4:0] txz_r; // Cycles the transmit gate has been off, saturating.
  // Ownership follows only writes that the block accepted.
  always_ff @(posedge clk) begin
    if (reset) owner_r <= 1'b0;
    else if (write && !waitrequest && address == 11'h000) owner_r <= writedata[0];
  end
  // Gates are forced on for merged simplex channels, so writes are ignored there.
  always_ff @(posedge clk) begin
    if (reset) gate_r <= 2'b11;
    else if (write && address == 11'h481 && !MERGED_SIMPLEX) gate_r <= writedata[5:4];
  end
  // The busy outputs are registered, so they may lag a closing gate by one cycle.
  always_ff @(posedge clk) begin
    if (reset || gate_r[1]) rxz_r <= 5'h00;
    else if (rxz_r != 5'h1F) rxz_r <= rxz_r + 5'h01;
    if (reset || gate_r[0]) txz_r <= 5'h00;
    else if (txz_r != 5'h1F) txz_r <= txz_r + 5'h01;
  end
  busy_delay_a: assert property ($rose(tx_cal_busy | rx_cal_busy | pll_cal_busy) |->
    $past(write && !waitrequest && address == 11'h000 && !writedata[1], 3))
    else $error("busy rose without a cleared done bit three cycles before");
  owner_wait_a: assert property ((read || write) && address == 11'h100 && owner_r
    && !SEPARATE_WAITREQ |-> waitrequest) else $error("enable access not stalled");
  status_free_a: assert property ((read || write) && address[10:1] == 10'h240
    |-> !waitrequest) else $error("status access stalled");
  wait_owner_a: assert property (waitrequest |-> owner_r)
    else $error("stall while the user owns the bus");
  ch_owner_a: assert property (read && !waitrequest && address == 11'h481
    |=> readdata[2] == $past(owner_r)) else $error("channel owner bit wrong");
  pll_owner_a: assert property (read && !waitrequest && address == 11'h480
    |=> readdata[2] == $past(owner_r)) else $error("pll owner bit wrong");
  enable_copy_a: assert property (write && !waitrequest && address == 11'h100 && !owner_r
    |-> ##2 cal_enable_out == $past(writedata, 2)) else $error("enable copy wrong");
  rate_copy_a: assert property (rate_switch_out == cal_enable_out[3])
    else $error("rate flag copy wrong");
  rx_gate_a: assert property (rxz_r != 5'h00 |-> !rx_cal_busy)
    else $error("receive busy while gated off");
  tx_gate_a: assert property (txz_r != 5'h00 |-> !tx_cal_busy)
    else $error("transmit busy while gated off");
endmodule
bind transceiver_calibration_control_regs transceiver_calibration_control_regs_checker #(
  .PLL_MODE(PLL_MODE), .SEPARATE_WAITREQ(SEPARATE_WAITREQ), .MERGED_SIMPLEX(MERGED_SIMPLEX)
) chk (.clk(clk), .reset(reset), .read(read), .write(write), .address(address),
  .writedata(writedata), .readdata(readdata), .waitrequest(waitrequest),
  .tx_cal_busy(tx_cal_busy), .rx_cal_busy(rx_cal_busy), .pll_cal_busy(pll_cal_busy),
  .cal_enable_out(cal_enable_out), .rate_switch_out(rate_switch_out));

// ===== tb/reconfig_host_model.sv
`timescale 1ns/1ps
// Reconfiguration host that drives the block at falling edges.
module reconfig_host_model (
  input wire logic clk,
  input wire logic waitrequest,
  input wire logic [7:0] readdata,
  output logic read,
  output logic write,
  output logic [10:0] address,
  output logic [7:0] writedata
);
  initial begin
    read = 1'b0;
    write = 1'b0;
    address = 11'h000;
    writedata = 8'h00;
  end
  // One access, held until taken; released lines show inverted junk, not the old value.
  task automatic xfer(input logic rd, input logic [10:0] a, input logic [7:0] d,
                      output logic [7:0] q);
    @(negedge clk);
    read = rd;
    write = !rd;
    address = a;
    writedata = d;
    @(posedge clk);
    // A stall that never ends keeps the request up, so the watchdog counts it.
    while (waitrequest) begin
      @(posedge clk);
    end
    @(negedge clk);
    q = readdata;
    read = 1'b0;
    write = 1'b0;
    address = ~a;
    writedata = ~d;
  endtask
  // A read that is meant to be refused: it samples the stall once and gives up.
  task automatic probe(input logic [10:0] a, output logic w);
    @(negedge clk);
    read = 1'b1;
    address = a;
    @(posedge clk);
    w = waitrequest;
    @(negedge clk);
    read = 1'b0;
    address = ~a;
  endtask
endmodule

// ===== tb/tb_transceiver_calibration_control_regs.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
// Runs calibrations with each gate setting except both off, and checks status on the way.
module tb_transceiver_calibration_control_regs;
  logic clk, reset, read, write, waitrequest, w;
  logic tx_cal_busy, rx_cal_busy, pll_cal_busy, rate_switch_out;
  logic [10:0] address;
  logic [7:0] writedata, readdata, cal_enable_out, q;
  // Gate settings to try: both on first, then one direction at a time.
  logic [7:0] gv [3] = '{8'h30, 8'h10, 8'h20};
  int err_total = 0;
  int checked = 0;
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  reconfig_host_model host (.clk(clk), .waitrequest(waitrequest), .readdata(readdata),
    .read(read), .write(write), .address(address), .writedata(writedata));
  transceiver_calibration_control_regs uut (.clk(clk), .reset(reset), .read(read),
    .write(write), .address(address), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .tx_cal_busy(tx_cal_busy), .rx_cal_busy(rx_cal_busy),
    .pll_cal_busy(pll_cal_busy), .cal_enable_out(cal_enable_out),
    .rate_switch_out(rate_switch_out));
  task automatic summarize();
    if (err_total == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // The whole run needs about 150 cycles, so this limit only trips on a hang.
  initial begin
    repeat (3000) @(posedge clk);
    err_total++;
    summarize();
  end
  initial begin
    reset = 1'b1;
    repeat (20) @(negedge clk);
    reset = 1'b0;
    host.xfer(1'b1, 11'h000, 8'h00, q); `CHK(q, 8'h02)
    host.xfer(1'b1, 11'h481, 8'h00, q); `CHK(q, 8'h30)
    host.xfer(1'b1, 11'h100, 8'h00, q); `CHK(q, 8'h00)
    host.xfer(1'b0, 11'h100, q | 8'h0B, q);
    // The enable copy is registered behind the register itself, so it lands a cycle later.
    @(negedge clk);
    `CHK({rate_switch_out, cal_enable_out}, 9'h10B)
    host.xfer(1'b0, 11'h480, 8'hFF, q);
    host.xfer(1'b1, 11'h480, 8'h00, q); `CHK(q, 8'h00)
    foreach (gv[i]) begin
      host.xfer(1'b0, 11'h481, gv[i], q);
      host.xfer(1'b0, 11'h000, 8'h01, q);
      // Busy shows at the second edge after the accepted write, not before.
      @(negedge clk);
      `CHK({pll_cal_busy, rx_cal_busy, tx_cal_busy}, 3'b000)
      @(negedge clk);
      `CHK({pll_cal_busy, rx_cal_busy, tx_cal_busy}, {1'b0, gv[i][5:4]})
      host.probe(11'h100, w); `CHK(w, 1'b1)
      host.xfer(1'b1, 11'h481, 8'h00, q); `CHK(q, gv[i] | 8'h04 | (gv[i] >> 4))
      // The engine run is sixteen cycles, so this is well past its end.
      repeat (20) @(negedge clk);
      host.xfer(1'b1, 11'h000, 8'h00, q); `CHK(q, 8'h03)
      host.xfer(1'b1, 11'h481, 8'h00, q); `CHK(q, gv[i] | 8'h04)
      host.xfer(1'b0, 11'h000, 8'h02, q);
      host.xfer(1'b1, 11'h480, 8'h00, q); `CHK(q, 8'h00)
    end
    summarize();
  end
endmodule
